// ==== bmc_phy_pkg.sv ====
// Shared constants and types for the configuration-channel line PHY
package bmc_phy_pkg;

  // ****************************************************************
  // Clock and line timing
  // ****************************************************************
  localparam int CLK_MHZ = 200;                 // Core clock rate
  localparam int UI_NS = 3333;                  // Nominal bit period in ns
  localparam int IDLE_NS = 12000;               // Quiet time before the wire counts as free
  // Cycle counts derived from the times above (every division rounds down)
  localparam int UI_CYC = (CLK_MHZ * UI_NS) / 1000;
  localparam int HALF_CYC = UI_CYC / 2;
  localparam int HALF_MIN_CYC = UI_CYC / 4;
  localparam int FULL_MIN_CYC = (UI_CYC * 3) / 4;
  localparam int FULL_MAX_CYC = (UI_CYC * 5) / 4;
  localparam int IDLE_CYC = (CLK_MHZ * IDLE_NS) / 1000;
  localparam int GAP_W = 12;                    // Interval counter width

  // ****************************************************************
  // Transmit buffer shape and reset values
  // ****************************************************************
  localparam int FIFO_DEPTH = 16;
  localparam int TX_W = 2;                      // {last, bit}
  localparam int TX_BIT_POS = 0;
  localparam int TX_LAST_POS = 1;
  localparam logic LINE_RST = 1'b0;
  localparam logic SEL_RST = 1'b0;

  // ****************************************************************
  // Transmitter states
  // ****************************************************************
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_PRE = 2'b01,
    TX_BIT = 2'b10,
    TX_TAIL = 2'b11
  } tx_state_t;

endpackage : bmc_phy_pkg

// ==== bit_stream_if.sv ====
// Valid/ready stream carrier between the PHY and its transmit buffer
`timescale 1ns/1ps
interface bit_stream_if #(parameter int WIDTH = 2) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : bit_stream_if

// ==== bit_fifo.sv ====
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module bit_fifo
  import bmc_phy_pkg::*;
#(
  parameter int WIDTH = TX_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  bit_stream_if.snk wr,
  bit_stream_if.src rd
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic rdy_reg;

  // Handshakes on each side; ready is registered so the source sees a clean level
  wire push = wr.valid & rdy_reg;
  wire pop = rd.valid & rd.ready;
  wire wp_wrap = (wp_reg == AW'(DEPTH - 1));
  wire rp_wrap = (rp_reg == AW'(DEPTH - 1));
  assign wr.ready = rdy_reg;
  assign rd.valid = (cnt_reg != '0);
  assign rd.data = mem[rp_reg];

  // Occupancy after this cycle's push and pop
  always_comb begin
    case ({push, pop})
      2'b10: cnt_next = cnt_reg + 1'b1;
      2'b01: cnt_next = cnt_reg - 1'b1;
      default: cnt_next = cnt_reg;
    endcase
  end

  // Storage has no reset: contents are only read once counted in
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= wr.data;
    end
  end

  // Pointers, count and ready; ready drops the cycle the last slot fills
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b0;
    end else begin
      if (push) begin
        wp_reg <= wp_wrap ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_wrap ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_next;
      rdy_reg <= (cnt_next != CW'(DEPTH));
    end
  end

endmodule : bit_fifo

// ==== bmc_cc_line_phy.sv ====
// Biphase-mark line PHY for one configuration-channel pin pair
`timescale 1ns/1ps
module bmc_cc_line_phy
  import bmc_phy_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic attached,
  input wire logic orient_flip,
  input wire logic tx_valid,
  input wire logic tx_bit,
  input wire logic tx_last,
  output logic tx_ready,
  output logic tx_busy,
  output logic rx_valid,
  output logic rx_bit,
  output logic line_idle,
  output logic active_cfg_pin,
  input wire logic cfg_pin_a_in,
  output logic cfg_pin_a_out,
  output logic cfg_pin_a_oe,
  input wire logic cfg_pin_b_in,
  output logic cfg_pin_b_out,
  output logic cfg_pin_b_oe
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_reg;
  logic rst_n;

  // Assert at once, release two edges later so all flops leave reset together
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // ****************************************************************
  // Transmit buffer
  // ****************************************************************
  bit_stream_if #(.WIDTH(TX_W)) wr_if ();
  bit_stream_if #(.WIDTH(TX_W)) rd_if ();

  assign wr_if.valid = tx_valid;
  assign wr_if.data = {tx_last, tx_bit};
  assign tx_ready = wr_if.ready;

  bit_fifo #(.WIDTH(TX_W), .DEPTH(DEPTH)) u_tx_fifo (
    .clk(mclk),
    .rst_n(rst_n),
    .wr(wr_if.snk),
    .rd(rd_if.src)
  );

  // ****************************************************************
  // Pin selection
  // ****************************************************************
  logic sel_reg;

  // Follow orientation only while detached; once attached the choice is held
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= SEL_RST;
    end else if (!attached) begin
      sel_reg <= orient_flip;
    end
  end
  // Held for the connection, so traffic never hops pins mid-connection
  assign active_cfg_pin = sel_reg;

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  tx_state_t st_reg;
  tx_state_t st_next;
  logic [GAP_W-1:0] hcnt_reg;
  logic lvl_reg;
  logic lvl_next;
  logic drv_reg;
  logic drv_next;
  logic cur_reg;
  logic cur_next;
  logic last_reg;
  logic last_next;
  logic half_reg;
  logic half_next;
  logic take;
  logic line_idle_reg;

  // Half-period enable: the only slow rate in the transmitter
  wire half_tick = (hcnt_reg == GAP_W'(HALF_CYC - 1));
  // Start only on a free, attached wire so two talkers never overlap
  wire tx_start = rd_if.valid & attached & line_idle_reg;
  wire head_bit = rd_if.data[TX_BIT_POS];
  wire head_last = rd_if.data[TX_LAST_POS];
  assign rd_if.ready = take;

  // Encoder next-state; level toggles at every bit start and at mid-bit for ones
  always_comb begin
    st_next = st_reg;
    lvl_next = lvl_reg;
    drv_next = drv_reg;
    cur_next = cur_reg;
    last_next = last_reg;
    half_next = half_reg;
    take = 1'b0;
    case (st_reg)
      TX_IDLE: begin
        drv_next = 1'b0;
        if (tx_start) begin
          st_next = TX_PRE;
          lvl_next = 1'b0;
          drv_next = 1'b1;
        end
      end
      TX_PRE: begin
        if (half_tick) begin
          take = 1'b1;
          lvl_next = ~lvl_reg;
          cur_next = head_bit;
          last_next = head_last;
          half_next = 1'b0;
          st_next = TX_BIT;
        end
      end
      TX_BIT: begin
        if (half_tick && !half_reg) begin
          half_next = 1'b1;
          if (cur_reg) begin
            lvl_next = ~lvl_reg;
          end
        end else if (half_tick) begin
          // Edge at every period end; after the last bit it is the closing edge
          lvl_next = ~lvl_reg;
          if (!last_reg && rd_if.valid) begin
            take = 1'b1;
            cur_next = head_bit;
            last_next = head_last;
            half_next = 1'b0;
          end else begin
            // A drained buffer ends the frame cleanly rather than stretch a bit
            st_next = TX_TAIL;
          end
        end
      end
      TX_TAIL: begin
        if (half_tick) begin
          drv_next = 1'b0;
          st_next = TX_IDLE;
        end
      end
      default: begin
        st_next = TX_IDLE;
        drv_next = 1'b0;
      end
    endcase
  end

  // Half-period divider runs only while a frame is on the wire
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hcnt_reg <= '0;
    end else if (st_reg == TX_IDLE || half_tick) begin
      hcnt_reg <= '0;
    end else begin
      hcnt_reg <= hcnt_reg + 1'b1;
    end
  end

  // Encoder state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= TX_IDLE;
      lvl_reg <= LINE_RST;
      drv_reg <= 1'b0;
      cur_reg <= 1'b0;
      last_reg <= 1'b0;
      half_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      lvl_reg <= lvl_next;
      drv_reg <= drv_next;
      cur_reg <= cur_next;
      last_reg <= last_next;
      half_reg <= half_next;
    end
  end

  // Pin drivers: only the selected pin is driven, the other always floats
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_pin_a_oe <= 1'b0;
      cfg_pin_b_oe <= 1'b0;
      cfg_pin_a_out <= LINE_RST;
      cfg_pin_b_out <= LINE_RST;
      tx_busy <= 1'b0;
    end else begin
      cfg_pin_a_oe <= drv_reg & ~sel_reg;
      cfg_pin_b_oe <= drv_reg & sel_reg;
      cfg_pin_a_out <= lvl_reg & ~sel_reg;
      cfg_pin_b_out <= lvl_reg & sel_reg;
      tx_busy <= (st_reg != TX_IDLE);
    end
  end

  // ****************************************************************
  // Receiver and idle watch
  // ****************************************************************
  logic line_prev_reg;
  logic [GAP_W-1:0] gap_reg;
  logic pend_reg;
  logic armed_reg;

  // Own transmission is not decoded; the wire is read only while listening
  wire listening = (st_reg == TX_IDLE) & ~drv_reg & ~cfg_pin_a_oe & ~cfg_pin_b_oe;
  wire line_in = sel_reg ? cfg_pin_b_in : cfg_pin_a_in;
  wire rx_edge = listening & armed_reg & (line_in ^ line_prev_reg); // No false edge out of reset
  wire gap_sat = (gap_reg == {GAP_W{1'b1}});
  // Interval classes against the nominal period
  wire is_half = (gap_reg >= GAP_W'(HALF_MIN_CYC)) & (gap_reg < GAP_W'(FULL_MIN_CYC));
  wire is_full = (gap_reg >= GAP_W'(FULL_MIN_CYC)) & (gap_reg <= GAP_W'(FULL_MAX_CYC));

  // Interval counter, restarted on every edge and saturating during silence
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_prev_reg <= LINE_RST;
      gap_reg <= '0; // Wire must prove a quiet spell after every reset
      armed_reg <= 1'b0;
      line_idle_reg <= 1'b0;
    end else begin
      line_prev_reg <= line_in;
      armed_reg <= 1'b1;
      if (!listening || rx_edge) begin
        gap_reg <= '0;
      end else if (!gap_sat) begin
        gap_reg <= gap_reg + 1'b1;
      end
      // Free only after a full quiet spell with nobody driving
      line_idle_reg <= listening & ~rx_edge & (gap_reg >= GAP_W'(IDLE_CYC));
    end
  end
  assign line_idle = line_idle_reg;

  // Bit recovery: two halves make a one, a full interval a zero.
  // An over-long interval only resynchronises, so a lost first edge costs nothing.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
      rx_valid <= 1'b0;
      rx_bit <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!listening) begin
        pend_reg <= 1'b0;
      end else if (rx_edge) begin
        if (is_half && pend_reg) begin
          pend_reg <= 1'b0;
          rx_valid <= 1'b1;
          rx_bit <= 1'b1;
        end else if (is_half) begin
          pend_reg <= 1'b1;
        end else if (is_full) begin
          // A stray half before a full is dropped so alignment recovers
          pend_reg <= 1'b0;
          rx_valid <= 1'b1;
          rx_bit <= 1'b0;
        end else begin
          pend_reg <= 1'b0;
        end
      end
    end
  end

  // Each port of a dual-port device instantiates this module once
  // with no shared state between instances.

endmodule : bmc_cc_line_phy

// ==== bmc_phy_asserts.sv ====
// Concurrent checks on the line PHY ports, bound to every PHY instance
`timescale 1ns/1ps
module bmc_phy_asserts
  import bmc_phy_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic attached,
  input wire logic tx_busy,
  input wire logic rx_valid,
  input wire logic line_idle,
  input wire logic active_cfg_pin,
  input wire logic cfg_pin_a_out,
  input wire logic cfg_pin_a_oe,
  input wire logic cfg_pin_b_oe
);
  logic [11:0] run_reg;
  logic prev_reg;

  // Cycles pin a has held its level while driven; a length beyond one bit is a balance fault
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_reg <= 12'h000;
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= cfg_pin_a_out;
      run_reg <= !cfg_pin_a_oe ? 12'h000 :
        (cfg_pin_a_out != prev_reg) ? 12'h001 : run_reg + 12'h001;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // *****************************
  // Line encoding
  // *****************************
  sequence lead_low;
    (cfg_pin_a_oe && !cfg_pin_a_out) [*8];
  endsequence
  sequence a_edge;
    cfg_pin_a_oe && $past(cfg_pin_a_oe) && $changed(cfg_pin_a_out);
  endsequence

  a_lead_low: assert property ($rose(cfg_pin_a_oe) |-> lead_low)
    else $error("frame did not open with a low level");
  a_run_length: assert property (a_edge |-> run_reg inside {HALF_CYC, UI_CYC})
    else $error("driven level held for a wrong span");
  a_close_hold: assert property ($fell(cfg_pin_a_oe) |-> run_reg == HALF_CYC)
    else $error("closing level not held half a bit");
  a_busy_drive: assert property ($rose(cfg_pin_a_oe) |-> tx_busy)
    else $error("pin driven without busy");

  // *****************************
  // Pin choice and sharing
  // *****************************
  a_one_talker: assert property (!(cfg_pin_a_oe && cfg_pin_b_oe))
    else $error("both pins driven");
  a_sel_pin_a: assert property (cfg_pin_a_oe |-> !active_cfg_pin)
    else $error("pin a driven while b selected");
  a_sel_pin_b: assert property (cfg_pin_b_oe |-> active_cfg_pin)
    else $error("pin b driven while a selected");
  a_pin_frozen: assert property (attached && $past(attached) |-> $stable(active_cfg_pin))
    else $error("pin choice moved while attached");
  a_start_gate: assert property ($rose(cfg_pin_a_oe) || $rose(cfg_pin_b_oe)
    |-> $past(line_idle, 2) && $past(attached, 2))
    else $error("frame started on busy wire or detached");
  a_rx_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("decoded bit strobe longer than one cycle");
  a_rx_quiet: assert property (rx_valid |-> !cfg_pin_a_oe && !cfg_pin_b_oe)
    else $error("own transmission decoded");
endmodule : bmc_phy_asserts

bind bmc_cc_line_phy bmc_phy_asserts chk (.mclk(mclk), .nrst(nrst), .attached(attached),
  .tx_busy(tx_busy), .rx_valid(rx_valid), .line_idle(line_idle),
  .active_cfg_pin(active_cfg_pin), .cfg_pin_a_out(cfg_pin_a_out),
  .cfg_pin_a_oe(cfg_pin_a_oe), .cfg_pin_b_oe(cfg_pin_b_oe));

// ==== cc_far_model.sv ====
// Remote port model that sends biphase-mark frames on the shared wire
`timescale 1ns/1ps
module cc_far_model (
  input wire logic clk,
  output logic far_oe,
  output logic far_out
);
  // Released until a frame is asked for
  initial begin
    far_oe = 1'b0;
    far_out = 1'b0;
  end

  // Bit 0 first; lose_first skips the lead-in so its edge never shows
  task automatic send(input logic [31:0] bits, input int n, input int half, input logic lose_first);
    logic lvl;
    lvl = 1'b0;
    @(posedge clk);
    far_oe <= 1'b1;
    far_out <= lvl;
    if (!lose_first) repeat (half) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      // A skipped lead-in leaves bit 0 on the level already driven
      if (i > 0 || !lose_first) begin
        lvl = ~lvl;
        far_out <= lvl;
      end
      repeat (half) @(posedge clk);
      if (bits[i]) lvl = ~lvl;
      far_out <= lvl;
      repeat (half) @(posedge clk);
    end
    far_out <= ~lvl;
    repeat (half) @(posedge clk);
    far_oe <= 1'b0;
  endtask : send
endmodule : cc_far_model

// ==== tb_top.sv ====
// Self-checking bench for the configuration-channel line PHY
`timescale 1ns/1ps
module tb_top;
  import bmc_phy_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic attached = 1'b0;
  logic orient_flip = 1'b0;
  logic tx_valid = 1'b0;
  logic tx_bit = 1'b0;
  logic tx_last = 1'b0;
  logic tx_ready, tx_busy, rx_valid, rx_bit, line_idle, active_cfg_pin;
  logic a_out, a_oe, b_out, b_oe, far_oe, far_out, pin_a, pin_b;
  logic [7:0] rx_sh = 8'h00;
  int rx_n = 0;
  int fail_count = 0;
  int total_checks = 0;

  always #2.5 mclk = ~mclk;
  // Whoever drives wins; a released wire returns to the high bias
  assign pin_a = a_oe ? a_out : (far_oe ? far_out : 1'b1);
  assign pin_b = b_oe ? b_out : 1'b1;
  // Last eight decoded bits, newest at the top
  // Bit counter shows each run decoded afresh, not a stale byte
  always @(posedge mclk) begin
    if (rx_valid) begin
      rx_sh <= {rx_bit, rx_sh[7:1]};
      rx_n <= rx_n + 1;
    end
  end

  bmc_cc_line_phy uut (.mclk(mclk), .nrst(nrst), .attached(attached),
    .orient_flip(orient_flip), .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_last(tx_last),
    .tx_ready(tx_ready), .tx_busy(tx_busy), .rx_valid(rx_valid), .rx_bit(rx_bit),
    .line_idle(line_idle), .active_cfg_pin(active_cfg_pin), .cfg_pin_a_in(pin_a),
    .cfg_pin_a_out(a_out), .cfg_pin_a_oe(a_oe), .cfg_pin_b_in(pin_b),
    .cfg_pin_b_out(b_out), .cfg_pin_b_oe(b_oe));
  cc_far_model far (.clk(mclk), .far_oe(far_oe), .far_out(far_out));

  // *****************************
  // Shared tasks
  // *****************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk

  task automatic wait_hi(ref logic s, input int lim, input string what);
    int n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(what, 1, s);
  endtask : wait_hi

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // *****************************
  // Scenarios
  // *****************************
  task automatic t_reset;
    #1;
    chk("tx_ready in reset", 0, tx_ready);
    wait_hi(tx_ready, 8, "tx_ready after reset");
    repeat (100) @(posedge mclk);
    #1;
    chk("line_idle early", 0, line_idle);
    wait_hi(line_idle, 2500, "line_idle");
  endtask : t_reset

  // Sixteen words fill the buffer while detached, a seventeenth is refused
  task automatic t_tx_frame;
    logic [15:0] d = 16'hb2d5;
    int exp[$];
    int got[$];
    int cnt;
    logic lvl;
    exp.push_back(HALF_CYC);
    for (int i = 0; i < 16; i++) begin
      if (d[i]) exp.push_back(HALF_CYC);
      exp.push_back(d[i] ? HALF_CYC : UI_CYC);
    end
    exp.push_back(HALF_CYC);
    for (int i = 0; i < 17; i++) begin
      tx_valid <= 1'b1;
      tx_bit <= d[i % 16];
      tx_last <= (i == 15);
      @(posedge mclk);
    end
    tx_valid <= 1'b0;
    #1;
    chk("tx_ready full", 0, tx_ready);
    @(posedge mclk);
    attached <= 1'b1;
    wait_hi(a_oe, 10, "pin a driven");
    chk("lead level", 0, a_out);
    while (a_oe === 1'b1) begin
      lvl = a_out;
      cnt = 0;
      while (a_oe === 1'b1 && a_out === lvl) begin
        @(posedge mclk);
        #1;
        cnt++;
      end
      got.push_back(cnt);
    end
    chk("run count", exp.size(), got.size());
    for (int i = 0; i < exp.size() && i < got.size(); i++)
      chk("run length", exp[i], got[i]);
    chk("bias back", 1, pin_a);
    chk("tx_ready drained", 1, tx_ready);
  endtask : t_tx_frame

  task automatic t_orient;
    @(posedge mclk);
    attached <= 1'b0;
    orient_flip <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk("pin b chosen", 1, active_cfg_pin);
    orient_flip <= 1'b0;
    @(posedge mclk);
    attached <= 1'b1;
    @(posedge mclk);
    orient_flip <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk("pin kept", 0, active_cfg_pin);
  endtask : t_orient

  // Remote frame: alternating lead bits, then one data byte
  task automatic t_rx(input int half, input logic lose);
    logic [31:0] d = 32'hc6aa_aaaa;
    int n0;
    repeat (1000) @(posedge mclk);
    n0 = rx_n;
    far.send(d, 32, half, lose);
    repeat (1000) @(posedge mclk);
    chk("rx bit count", 32, rx_n - n0);
    chk("rx byte", d[31:24], rx_sh);
  endtask : t_rx

  // Short frame on pin b after re-plugging the other way round
  task automatic t_tx_pin_b;
    int n = 0;
    @(posedge mclk);
    attached <= 1'b0;
    orient_flip <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      tx_valid <= 1'b1;
      tx_bit <= i[0];
      tx_last <= (i == 3);
      @(posedge mclk);
    end
    tx_valid <= 1'b0;
    attached <= 1'b1;
    wait_hi(b_oe, 3000, "pin b driven");
    chk("pin b lead level", 0, b_out);
    chk("pin a idle", 0, a_oe);
    chk("busy while sending", 1, tx_busy);
    while (b_oe === 1'b1 && n < 4000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("pin b released", 0, b_oe);
    chk("bias back on b", 1, pin_b);
    chk("busy after frame", 0, tx_busy);
  endtask : t_tx_pin_b

  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    t_reset;
    t_tx_frame;
    t_orient;
    t_rx(HALF_CYC, 1'b0);
    t_rx(360, 1'b1);
    t_tx_pin_b;
    finish_test;
  end

  // Watchdog well past the longest expected run
  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    finish_test;
  end
endmodule : tb_top
